// ---- core/pcrvf_pkg.sv ----
// Purpose: shared constants of the synthesizer control bank and its vco forwarding link
// Assumes: 24-bit register words, 5-bit register index, 3-bit chip address on the serial port
// Notes: register indexes are the serial-port addresses

package pcrvf_pkg;

  // ===========================================
  // serial port framing
  localparam int FRAME_BITS = 32;
  localparam int DATA_W = 24;
  localparam int ADDR_W = 5;
  localparam int CHIP_W = 3;
  localparam logic [2:0] OWN_CHIP_ADDR = 3'h0;

  // ===========================================
  // register indexes
  localparam logic [4:0] ADDR_ID_READSEL = 5'h00;
  localparam logic [4:0] ADDR_POWER_ENABLE = 5'h01;
  localparam logic [4:0] ADDR_REF_DIVIDE = 5'h02;
  localparam logic [4:0] ADDR_WHOLE_PART = 5'h03;
  localparam logic [4:0] ADDR_REMAINDER = 5'h04;
  localparam logic [4:0] ADDR_VCO_PACKET = 5'h05;

  // ===========================================
  // field layouts
  localparam int READSEL_LSB = 0;
  localparam int READSEL_W = 5;
  localparam int SOFT_RESET_BIT = 5;
  localparam int PIN_SELECT_BIT = 0;
  localparam int SW_ENABLE_BIT = 1;
  localparam int HOLD_LSB = 2;
  localparam int HOLD_W = 6;
  localparam int POWER_CTL_W = 10;
  localparam int REF_DIV_W = 14;
  localparam int WHOLE_W = 19;
  localparam int REMAINDER_W = 24;
  localparam int PACKET_W = 16;
  localparam int SUBSYS_LSB = 0;
  localparam int SUBSYS_W = 3;
  localparam int INDEX_LSB = 3;
  localparam int INDEX_W = 4;
  localparam int PAYLOAD_LSB = 7;
  localparam int PAYLOAD_W = 9;
  localparam int RATE_SEL_W = 2;

  // ===========================================
  // reset values
  localparam logic [9:0] POWER_CTL_RESET = 10'h002;
  localparam logic [13:0] REF_DIV_RESET = 14'h0001;
  localparam logic [13:0] REF_DIV_MIN = 14'h0001;
  localparam logic [18:0] WHOLE_RESET = 19'h00019;
  localparam logic [23:0] REMAINDER_RESET = 24'h000000;
  localparam logic [15:0] PACKET_RESET = 16'h0000;

endpackage

// ---- core/pcrvf_sync.sv ----
// Purpose: two-flop synchroniser for a group of pin inputs
// Assumes: inputs are independent levels
// Notes: only the second stage is visible outside

`timescale 1ns/1ps

module pcrvf_sync #(
  parameter int WIDTH = 5
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  typedef struct packed {
    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
  } pcrvf_sync_state_t;

  pcrvf_sync_state_t st;
  pcrvf_sync_state_t next_st;

  always_comb
  begin
    next_st.stage1 = async_in;
    next_st.stage2 = st.stage1;
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      st <= '0;
    end
    else
    begin
      st <= next_st;
    end
  end

  assign sync_out = st.stage2;

endmodule

// ---- core/pcrvf_vco_link.sv ----
// Purpose: shifts one 16-bit packet to the vco subsystem over the internal link
// Assumes: clk is the calibration state machine clock, at most 50 MHz
// Notes: link clock half period is 2**rate_sel cycles; data changes on falling link clock

`timescale 1ns/1ps

module pcrvf_vco_link
  import pcrvf_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic [pcrvf_pkg::RATE_SEL_W-1:0] rate_sel,
  input wire logic start,
  input wire logic [pcrvf_pkg::PACKET_W-1:0] packet,
  output logic busy,
  output logic link_clk,
  output logic link_data,
  output logic link_frame
);

  typedef struct packed {
    logic [2:0] tick_cnt;
    logic [PACKET_W-1:0] shreg;
    logic [4:0] bits_left;
    logic frame;
    logic lclk;
    logic ldat;
  } pcrvf_link_state_t;

  pcrvf_link_state_t st;
  pcrvf_link_state_t next_st;

  function automatic logic [2:0] half_period_last(input logic [RATE_SEL_W-1:0] sel);
    half_period_last = 3'((4'h1 << sel) - 4'h1);
  endfunction

  always_comb
  begin
    next_st = st;
    if (!st.frame)
    begin
      if (start) // [R20]
      begin
        next_st.frame = 1'b1;
        next_st.lclk = 1'b0;
        next_st.ldat = packet[PACKET_W-1]; // [R17]
        next_st.shreg = {packet[PACKET_W-2:0], 1'b0};
        next_st.bits_left = 5'(PACKET_W);
        next_st.tick_cnt = 3'h0;
      end
    end
    else if (st.tick_cnt == half_period_last(rate_sel)) // [R18]
    begin
      next_st.tick_cnt = 3'h0;
      if (!st.lclk)
      begin
        next_st.lclk = 1'b1;
      end
      else
      begin
        next_st.lclk = 1'b0;
        next_st.bits_left = st.bits_left - 5'h1;
        if (st.bits_left == 5'h1)
        begin
          next_st.frame = 1'b0;
          next_st.ldat = 1'b0;
        end
        else
        begin
          next_st.ldat = st.shreg[PACKET_W-1]; // [R17]
          next_st.shreg = {st.shreg[PACKET_W-2:0], 1'b0};
        end
      end
    end
    else
    begin
      next_st.tick_cnt = st.tick_cnt + 3'h1;
    end
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      st <= '0;
    end
    else
    begin
      st <= next_st;
    end
  end

  assign busy = st.frame;
  assign link_clk = st.lclk;
  assign link_data = st.ldat;
  assign link_frame = st.frame;

endmodule

// ---- core/pcrvf_top.sv ----
// Purpose: control register bank of a fractional-n synthesizer with vco packet forwarding
// Assumes: open-mode serial port (sclk, sdi, sen) sampled by clk; clk is the calibration fsm clock
// Notes: one pending forward is held while the link is busy
// Notes on behaviour
// [R1] vco packet splits into subsystem code 2..0, register index 6..3, payload 15..7.
// [R2] host puts subsystem code zero in every packet meant for the vco.
// [R3] calibration overwrites only the payload; index must be zero to reach target.
// [R4] calibration keeps code and index; host restores index zero after manual access.
// [R5] every host write of the indirect register starts a forward transfer; a write replaced by a newer request before the link takes it is never sent.
// [R6] host preserves switch bits by rewriting readback bits into packet 15..8 before reset.
// [R7] manual reset packet carries tune voltage off bit 7 zero plus select, caps.
// [R8] reading address zero returns a fixed 24-bit identification word.
// [R9] write bits 4..0 at address zero pick the next readback register.
// [R10] bit 5 at address zero resets the serial interface; host writes zero normally.
// [R11] host writes zeros to bits 23..6 of address zero.
// [R12] enable follows power gate pin when bit 0 set, else software bit 1.
// [R13] bits 2..7 each keep one block powered while the synthesizer is disabled.
// [R14] reference divide ratio is 14 bits, 1 to 16383, needs reference buffer enable.
// [R15] host keeps whole divider part within mode limits; it resets to 25.
// [R16] remainder word is a 24-bit fraction, used only in fractional mode.
// [R17] packets go out most significant bit first on the internal link.
// [R18] internal link runs from the calibration clock at a selectable rate.
// [R19] reading the indirect register returns the last forwarded packet.
// [R20] a transfer finishes before the next starts; writes delivered whole, in order; code keeps one pending packet that any newer request overwrites.

`timescale 1ns/1ps

module pcrvf_top
  import pcrvf_pkg::*;
#(
  // arbitrary identification value
  parameter logic [23:0] ID_WORD = 24'h5A0C31
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic sclk,
  input wire logic sdi,
  input wire logic sen,
  input wire logic pin_power_gate,
  input wire logic lock_detect,
  input wire logic fractional_mode,
  input wire logic reference_buffer_enable,
  input wire logic [pcrvf_pkg::RATE_SEL_W-1:0] link_rate_sel,
  input wire logic cal_payload_valid,
  input wire logic [pcrvf_pkg::PAYLOAD_W-1:0] cal_payload,
  output logic lock_or_serial_output,
  output logic synth_enable,
  output logic [pcrvf_pkg::HOLD_W-1:0] block_powered,
  output logic [pcrvf_pkg::REF_DIV_W-1:0] ref_divide_ratio,
  output logic ref_divider_run,
  output logic [pcrvf_pkg::WHOLE_W-1:0] divider_whole_part,
  output logic [pcrvf_pkg::REMAINDER_W-1:0] divider_remainder,
  output logic link_clk,
  output logic link_data,
  output logic link_frame
);

  // ===========================================
  // state
  typedef struct packed {
    logic sclk_d;
    logic sen_d;
    logic [FRAME_BITS-1:0] shift_in;
    logic [5:0] bit_cnt;
    logic [DATA_W-1:0] shift_out;
    logic [READSEL_W-1:0] read_sel;
    logic [POWER_CTL_W-1:0] power_ctl;
    logic [REF_DIV_W-1:0] ref_div;
    logic [WHOLE_W-1:0] whole;
    logic [REMAINDER_W-1:0] remainder;
    logic [PACKET_W-1:0] packet;
    logic [PACKET_W-1:0] last_sent;
    logic pend;
    logic [PACKET_W-1:0] pend_packet;
    logic sdo;
    logic en;
    logic [HOLD_W-1:0] powered;
    logic [REF_DIV_W-1:0] ref_div_out;
    logic ref_run;
    logic [WHOLE_W-1:0] whole_out;
    logic [REMAINDER_W-1:0] remainder_out;
  } pcrvf_top_state_t;

  pcrvf_top_state_t st;
  pcrvf_top_state_t next_st;

  logic [4:0] pins_s;
  logic sclk_s;
  logic sdi_s;
  logic sen_s;
  logic gate_s;
  logic lock_s;
  logic link_busy;
  logic link_start;

  // ===========================================
  // pin synchronisers
  pcrvf_sync #(
    .WIDTH(5)
  ) u_sync (
    .clk(clk),
    .nrst(nrst),
    .async_in({lock_detect, pin_power_gate, ~sen, sdi, sclk}),
    .sync_out(pins_s)
  );

  assign sclk_s = pins_s[0];
  assign sdi_s = pins_s[1];
  // enable travels inverted: cleared flops read as idle high, no false frame after reset
  assign sen_s = ~pins_s[2];
  assign gate_s = pins_s[3];
  assign lock_s = pins_s[4];

  // ===========================================
  // readback mux
  function automatic logic [DATA_W-1:0] read_word(
    input logic [ADDR_W-1:0] addr,
    input pcrvf_top_state_t s
  );
    read_word = '0;
    unique case (addr)
      ADDR_ID_READSEL: read_word = ID_WORD; // [R8]
      ADDR_POWER_ENABLE: read_word = DATA_W'(s.power_ctl);
      ADDR_REF_DIVIDE: read_word = DATA_W'(s.ref_div);
      ADDR_WHOLE_PART: read_word = DATA_W'(s.whole);
      ADDR_REMAINDER: read_word = s.remainder;
      ADDR_VCO_PACKET: read_word = DATA_W'(s.last_sent); // [R19]
      default: read_word = '0;
    endcase
  endfunction

  // ===========================================
  // forwarding hand-off
  assign link_start = st.pend & ~link_busy; // [R20]

  pcrvf_vco_link u_link (
    .clk(clk),
    .nrst(nrst),
    .rate_sel(link_rate_sel),
    .start(link_start),
    .packet(st.pend_packet),
    .busy(link_busy),
    .link_clk(link_clk),
    .link_data(link_data),
    .link_frame(link_frame)
  );

  // ===========================================
  // next state
  logic sclk_rise;
  logic sen_fall;
  logic sen_rise;
  logic [DATA_W-1:0] wr_data;
  logic [ADDR_W-1:0] wr_addr;
  logic [CHIP_W-1:0] wr_chip;
  logic wr_ok;
  logic fwd_req;
  logic [PACKET_W-1:0] fwd_packet;
  logic [REF_DIV_W-1:0] div_req;

  always_comb
  begin
    next_st = st;
    sclk_rise = sclk_s & ~st.sclk_d;
    sen_fall = ~sen_s & st.sen_d;
    sen_rise = sen_s & ~st.sen_d;
    wr_data = st.shift_in[FRAME_BITS-1 -: DATA_W];
    wr_addr = st.shift_in[CHIP_W +: ADDR_W];
    wr_chip = st.shift_in[CHIP_W-1:0];
    wr_ok = sen_rise && (st.bit_cnt == 6'(FRAME_BITS)) && (wr_chip == OWN_CHIP_ADDR);
    fwd_req = 1'b0;
    fwd_packet = st.packet;
    div_req = wr_data[REF_DIV_W-1:0];

    next_st.sclk_d = sclk_s;
    next_st.sen_d = sen_s;

    // serial shifting while the enable is low
    if (sen_fall)
    begin
      next_st.bit_cnt = 6'h00;
      next_st.shift_out = read_word(st.read_sel, st); // [R9]
    end
    else if (!sen_s && sclk_rise)
    begin
      next_st.shift_in = {st.shift_in[FRAME_BITS-2:0], sdi_s};
      if (st.bit_cnt != 6'h3F)
      begin
        next_st.bit_cnt = st.bit_cnt + 6'h01;
      end
      next_st.shift_out = {st.shift_out[DATA_W-2:0], 1'b0};
    end

    // calibration writes the payload only
    if (cal_payload_valid)
    begin
      fwd_packet[PAYLOAD_LSB +: PAYLOAD_W] = cal_payload; // [R3] [R4]
      fwd_req = 1'b1;
    end

    // register writes on the enable rising edge
    if (wr_ok)
    begin
      unique case (wr_addr)
        ADDR_ID_READSEL:
        begin
          if (wr_data[SOFT_RESET_BIT]) // [R10]
          begin
            next_st.read_sel = '0;
            next_st.shift_in = '0;
            next_st.shift_out = '0;
            next_st.bit_cnt = 6'h00;
          end
          else
          begin
            next_st.read_sel = wr_data[READSEL_LSB +: READSEL_W]; // [R9]
          end
        end
        ADDR_POWER_ENABLE: next_st.power_ctl = wr_data[POWER_CTL_W-1:0];
        ADDR_REF_DIVIDE: next_st.ref_div = (div_req < REF_DIV_MIN) ? REF_DIV_MIN : div_req; // [R14]
        ADDR_WHOLE_PART: next_st.whole = wr_data[WHOLE_W-1:0];
        ADDR_REMAINDER: next_st.remainder = wr_data[REMAINDER_W-1:0];
        ADDR_VCO_PACKET:
        begin
          fwd_packet = wr_data[PACKET_W-1:0]; // [R5]
          fwd_req = 1'b1;
        end
        default:
        begin
          next_st.read_sel = st.read_sel;
        end
      endcase
    end

    // forward queue of one; link start drains it
    next_st.packet = fwd_packet;
    if (link_start)
    begin
      next_st.pend = 1'b0;
      next_st.last_sent = st.pend_packet; // [R19]
    end
    if (fwd_req)
    begin
      next_st.pend = 1'b1;
      next_st.pend_packet = fwd_packet; // [R1]
    end

    // serial output: data during a frame, lock detect otherwise
    next_st.sdo = sen_s ? lock_s : next_st.shift_out[DATA_W-1];

    // power control
    next_st.en = st.power_ctl[PIN_SELECT_BIT] ? gate_s : st.power_ctl[SW_ENABLE_BIT]; // [R12]
    for (int i = 0; i < HOLD_W; i++)
    begin
      next_st.powered[i] = next_st.en | st.power_ctl[HOLD_LSB + i]; // [R13]
    end

    // divider words
    next_st.ref_div_out = st.ref_div;
    next_st.ref_run = reference_buffer_enable; // [R14]
    next_st.whole_out = st.whole;
    next_st.remainder_out = fractional_mode ? st.remainder : REMAINDER_RESET; // [R16]
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      st <= '0;
      st.sclk_d <= 1'b0;
      st.sen_d <= 1'b1;
      st.power_ctl <= POWER_CTL_RESET; // [R12]
      st.ref_div <= REF_DIV_RESET;
      st.ref_div_out <= REF_DIV_RESET;
      st.whole <= WHOLE_RESET;
      st.whole_out <= WHOLE_RESET;
      st.remainder <= REMAINDER_RESET;
      st.packet <= PACKET_RESET;
      st.last_sent <= PACKET_RESET;
      st.en <= 1'b1;
      st.powered <= '1;
    end
    else
    begin
      st <= next_st;
    end
  end

  // ===========================================
  // outputs
  assign lock_or_serial_output = st.sdo;
  assign synth_enable = st.en;
  assign block_powered = st.powered;
  assign ref_divide_ratio = st.ref_div_out;
  assign ref_divider_run = st.ref_run;
  assign divider_whole_part = st.whole_out;
  assign divider_remainder = st.remainder_out;

endmodule

// ---- dv/pcrvf_top_asserts.sv ----
// Purpose: port checks of the synthesizer control bank
// Assumes: one clk domain, nrst async active low
// Notes: attached to pcrvf_top by the bind at the foot
`timescale 1ns/1ps
module pcrvf_top_asserts (
  input wire logic clk,
  input wire logic nrst,
  input wire logic sen,
  input wire logic lock_detect,
  input wire logic fractional_mode,
  input wire logic reference_buffer_enable,
  input wire logic [pcrvf_pkg::RATE_SEL_W-1:0] link_rate_sel,
  input wire logic lock_or_serial_output,
  input wire logic synth_enable,
  input wire logic [pcrvf_pkg::HOLD_W-1:0] block_powered,
  input wire logic ref_divider_run,
  input wire logic [pcrvf_pkg::REMAINDER_W-1:0] divider_remainder,
  input wire logic link_clk,
  input wire logic link_data,
  input wire logic link_frame
);
  import pcrvf_pkg::*;
  logic prev_lc;
  logic prev_fr;
  logic [4:0] rises;
  // ===========================================
  // link clock rises within one frame
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      prev_lc <= 1'b0;
      prev_fr <= 1'b0;
      rises <= 5'h00;
    end
    else
    begin
      prev_lc <= link_clk;
      prev_fr <= link_frame;
      if (link_frame && !prev_fr)
        rises <= 5'h00;
      else if (link_clk && !prev_lc)
        rises <= rises + 5'h01;
    end
  end
  // ===========================================
  // properties
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  property p_idle; !link_frame |-> !link_clk; endproperty
  a_idle: assert property (p_idle) else $error("link clock runs outside frame");
  property p_hold; link_clk |-> $stable(link_data); endproperty
  a_hold: assert property (p_hold) else $error("link data moved while clock high");
  property p_len; $fell(link_frame) |=> rises == 5'h10; endproperty
  a_len: assert property (p_len) else $error("frame without 16 link bits");
  property p_gap; $fell(link_frame) |-> !link_clk && !link_data; endproperty
  a_gap: assert property (p_gap) else $error("link not idle at frame end");
  property p_rate; $rose(link_clk) && link_rate_sel == 2'h0 |=> !link_clk; endproperty
  a_rate: assert property (p_rate) else $error("link half period wrong");
  property p_lock; (sen && $stable(lock_detect)) [*7] |-> lock_or_serial_output == lock_detect; endproperty
  a_lock: assert property (p_lock) else $error("serial output not lock detect");
  property p_frac; !fractional_mode |=> divider_remainder == 24'h000000; endproperty
  a_frac: assert property (p_frac) else $error("remainder passed in integer mode");
  property p_pow; synth_enable [*2] |-> block_powered == 6'h3F; endproperty
  a_pow: assert property (p_pow) else $error("block off while enabled");
  property p_run; reference_buffer_enable |=> ref_divider_run; endproperty
  a_run: assert property (p_run) else $error("ref divider idle with buffer on");
  c_frame: cover property ($fell(link_frame));
  c_off: cover property (!synth_enable);
  c_read: cover property (!sen && lock_or_serial_output);
endmodule

bind pcrvf_top pcrvf_top_asserts u_chk (.clk(clk), .nrst(nrst), .sen(sen), .lock_detect(lock_detect),
  .fractional_mode(fractional_mode), .reference_buffer_enable(reference_buffer_enable),
  .link_rate_sel(link_rate_sel), .lock_or_serial_output(lock_or_serial_output), .synth_enable(synth_enable),
  .block_powered(block_powered), .ref_divider_run(ref_divider_run), .divider_remainder(divider_remainder),
  .link_clk(link_clk), .link_data(link_data), .link_frame(link_frame));

// ---- dv/pcrvf_host.sv ----
// Purpose: host controller model on the open-mode serial port
// Assumes: sclk period 320 ns, idle low between frames
// Notes: sdi shows the inverse of its last bit while deselected
`timescale 1ns/1ps
module pcrvf_host (
  output logic sclk,
  output logic sdi,
  output logic sen,
  input wire logic sdo
);
  initial
  begin
    sclk = 1'b0;
    sdi = 1'b0;
    sen = 1'b1;
  end
  // ===========================================
  // one 32-bit frame, readback sampled before each of the first 24 rises
  task automatic xfer(input logic [31:0] frame, output logic [23:0] rb);
    #7;
    sen = 1'b0;
    #160;
    for (int i = 0; i < 32; i++)
    begin
      sdi = frame[31-i];
      #160;
      if (i < 24)
        rb[23-i] = sdo;
      sclk = 1'b1;
      #160;
      sclk = 1'b0;
    end
    #160;
    sen = 1'b1;
    sdi = ~sdi;
    #400;
  endtask
  task automatic wr(input logic [4:0] a, input logic [23:0] v);
    logic [23:0] junk;
    xfer({v, a, 3'h0}, junk);
  endtask
  // select then read; upper select bits and soft reset left zero
  task automatic rd(input logic [4:0] a, output logic [23:0] d);
    xfer({19'h00000, a, 5'h00, 3'h0}, d);
    xfer({19'h00000, a, 5'h00, 3'h0}, d);
  endtask
endmodule

// ---- dv/tb.sv ----
// Purpose: self-checking bench of the synthesizer control bank
// Assumes: clk 25 MHz, serial port driven by pcrvf_host
// Notes: random values from an xorshift sequence
`timescale 1ns/1ps
module tb;
  import pcrvf_pkg::*;
  localparam logic [23:0] ID = 24'h3C5A96; // arbitrary identification value
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic sclk, sdi, sen;
  logic pin_power_gate = 1'b0;
  logic lock_detect = 1'b0;
  logic fractional_mode = 1'b1;
  logic reference_buffer_enable = 1'b0;
  logic [1:0] link_rate_sel = 2'h0;
  logic cal_payload_valid = 1'b0;
  logic [8:0] cal_payload = 9'h000;
  logic lock_or_serial_output, synth_enable, ref_divider_run, link_clk, link_data, link_frame;
  logic [5:0] block_powered;
  logic [13:0] ref_divide_ratio;
  logic [18:0] divider_whole_part;
  logic [23:0] divider_remainder;
  logic [31:0] seed = 32'h0000FD79;
  logic [15:0] got_q[$];
  logic [15:0] exp_q[$];
  logic [15:0] sh = 16'h0000;
  logic prev_lc = 1'b0;
  logic prev_fr = 1'b0;
  int fail_count = 0;
  int tests_run = 0;
  int cyc = 0;
  always #20 clk = ~clk;
  pcrvf_top #(.ID_WORD(ID)) u_dut (.clk, .nrst, .sclk, .sdi, .sen, .pin_power_gate, .lock_detect,
    .fractional_mode, .reference_buffer_enable, .link_rate_sel, .cal_payload_valid, .cal_payload,
    .lock_or_serial_output, .synth_enable, .block_powered, .ref_divide_ratio, .ref_divider_run,
    .divider_whole_part, .divider_remainder, .link_clk, .link_data, .link_frame);
  pcrvf_host u_host (.sclk, .sdi, .sen, .sdo(lock_or_serial_output));
  // ===========================================
  // helpers
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  function automatic logic [23:0] exp_rb(input logic [4:0] a, input logic [23:0] v);
    case (a)
      5'h01: return {14'h0000, v[9:0]};
      5'h02: return (v[13:0] == 14'h0000) ? 24'h000001 : {10'h000, v[13:0]};
      5'h03: return {5'h00, v[18:0]};
      5'h04: return v;
      5'h05: return {8'h00, v[15:0]};
      default: return 24'h000000;
    endcase
  endfunction
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      fail_count++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wait_pk(input int n);
    for (int i = 0; i < 3000 && got_q.size() < n; i++)
      @(posedge clk);
  endtask
  task automatic tally_and_finish();
    $display("tests_run=%0d fail_count=%0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // ===========================================
  // link capture and run limit
  always @(posedge clk)
  begin
    cyc++;
    if (link_clk && !prev_lc)
      sh = {sh[14:0], link_data};
    if (prev_fr && !link_frame)
      got_q.push_back(sh);
    prev_lc = link_clk;
    prev_fr = link_frame;
    if (cyc == 40000)
    begin
      fail_count++;
      $display("MISMATCH t=%0t run limit reached", $time);
      tally_and_finish();
    end
  end
  // ===========================================
  // main sequence
  initial
  begin
    logic [23:0] v, d, w3;
    logic [15:0] p;
    logic [8:0] c;
    logic [4:0] a;
    logic [5:0] h;
    w3 = 24'h000019;
    repeat (10) @(posedge clk);
    nrst <= 1'b1;
    repeat (3) @(posedge clk);
    chk({10'h000, ref_divide_ratio}, 24'h000001);
    chk({5'h00, divider_whole_part}, w3);
    chk(divider_remainder, 24'h000000);
    chk({17'h00000, synth_enable, block_powered}, 24'h00007F);
    u_host.rd(5'h00, d);
    chk(d, ID);
    for (int k = 0; k < 9; k++)
    begin
      a = 5'(2 + k % 3);
      v = (k == 0) ? 24'h000000 : 24'(rnd());
      if (a == 5'h03)
        v = 24'(20 + rnd() % 524265);
      if (a == 5'h03)
        w3 = v;
      @(posedge clk);
      reference_buffer_enable <= 1'(rnd());
      lock_detect <= 1'(rnd());
      u_host.wr(a, v);
      d = (a == 5'h02) ? {10'h000, ref_divide_ratio} : (a == 5'h03) ? {5'h00, divider_whole_part} : divider_remainder;
      chk(d, exp_rb(a, v));
      chk({23'h000000, ref_divider_run}, {23'h000000, reference_buffer_enable});
      u_host.rd(a, d);
      chk(d, exp_rb(a, v));
    end
    u_host.xfer({24'h0000FF, 5'h03, 3'h1}, d);
    chk({5'h00, divider_whole_part}, w3);
    @(posedge clk);
    fractional_mode <= 1'b0;
    repeat (3) @(posedge clk);
    chk(divider_remainder, 24'h000000);
    u_host.wr(5'h01, 24'h000001);
    @(posedge clk);
    pin_power_gate <= 1'b1;
    repeat (6) @(posedge clk);
    chk({23'h000000, synth_enable}, 24'h000001);
    pin_power_gate <= 1'b0;
    repeat (6) @(posedge clk);
    chk({17'h00000, synth_enable, block_powered}, 24'h000000);
    h = 6'(rnd());
    u_host.wr(5'h01, {16'h0000, h, 2'h0});
    chk({17'h00000, synth_enable, block_powered}, {18'h00000, h});
    u_host.rd(5'h01, d);
    chk(d, {16'h0000, h, 2'h0});
    u_host.wr(5'h01, 24'h000002);
    chk({23'h000000, synth_enable}, 24'h000001);
    u_host.wr(5'h00, 24'h000023);
    u_host.xfer({24'h000000, 5'h04, 3'h0}, d);
    chk(d, ID);
    for (int s = 0; s < 4; s++)
    begin
      @(posedge clk);
      link_rate_sel <= 2'(s);
      p = {9'(rnd()), 4'(rnd()), 3'h0};
      u_host.wr(5'h05, {8'h00, p});
      exp_q.push_back(p);
      wait_pk(exp_q.size());
    end
    p = {9'(rnd()), 4'h9, 3'h0};
    u_host.wr(5'h05, {8'h00, p});
    exp_q.push_back(p);
    @(posedge clk);
    c = 9'(rnd());
    cal_payload <= c;
    cal_payload_valid <= 1'b1;
    @(posedge clk);
    cal_payload_valid <= 1'b0;
    exp_q.push_back({c, p[6:0]});
    wait_pk(exp_q.size());
    u_host.rd(5'h05, d);
    chk(d, {8'h00, c, p[6:0]});
    u_host.rd(5'h10, d);
    chk(d, 24'h000000);
    p = {d[7:0], 1'b0, 4'h0, 3'h0};
    u_host.wr(5'h05, {8'h00, p});
    exp_q.push_back(p);
    wait_pk(exp_q.size());
    chk(24'(got_q.size()), 24'(exp_q.size()));
    foreach (exp_q[i])
      chk({8'h00, got_q[i]}, {8'h00, exp_q[i]});
    tally_and_finish();
  end
endmodule
